//--- rtl/dtc_pkg.sv
// Register map, field layouts and encodings of the dual timer/counter block
package dtc_pkg;

    localparam int ADR_W = 8;

    // Word offsets on the register bus
    localparam logic [ADR_W-1:0] OFS_CNT1  = 8'h00;
    localparam logic [ADR_W-1:0] OFS_RCA   = 8'h04;
    localparam logic [ADR_W-1:0] OFS_RB    = 8'h08;
    localparam logic [ADR_W-1:0] OFS_CNT2  = 8'h0c;
    localparam logic [ADR_W-1:0] OFS_PSC   = 8'h10;
    localparam logic [ADR_W-1:0] OFS_CKSEL = 8'h14;
    localparam logic [ADR_W-1:0] OFS_CTRL  = 8'h18;
    localparam logic [ADR_W-1:0] OFS_PEND  = 8'h1c;
    localparam logic [ADR_W-1:0] OFS_PCLR  = 8'h20;

    // Reset values and fixed values
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [7:0]  CKSEL_RST  = 8'h00;
    localparam logic [4:0]  PSC_RST    = 5'h00;
    localparam logic [3:0]  PEND_RST   = 4'h0;
    localparam logic [15:0] PRESET_VAL = 16'hffff;
    localparam logic [7:0]  PCLR_READ  = 8'hff;

    // Field positions
    localparam int CTRL_OUT_BIT = 6;
    localparam int PEND_A       = 0;
    localparam int PEND_B       = 1;
    localparam int PEND_C       = 2;
    localparam int PEND_D       = 3;
    localparam logic [7:0] CTRL_RW_MASK  = 8'hd7;
    localparam logic [7:0] CKSEL_RW_MASK = 8'h3f;

    typedef enum logic [1:0] {
        MODE_PWM     = 2'b00,
        MODE_CAPTURE = 2'b01,
        MODE_DUAL    = 2'b10,
        MODE_RSVD    = 2'b11
    } dtc_mode_e;

    typedef enum logic [2:0] {
        CK_STOP   = 3'b000,
        CK_PRESC  = 3'b001,
        CK_SRC2   = 3'b010,
        CK_SRC3   = 3'b011,
        CK_SRC4   = 3'b100,
        CK_SRC5   = 3'b101,
        CK_RSVD6  = 3'b110,
        CK_RSVD7  = 3'b111
    } dtc_cksrc_e;

    typedef struct packed {
        logic       module_enable;
        logic       pin_output_level;
        logic       rsv5;
        logic       pin_function_enable;
        logic       rsv3;
        logic       pin_edge_polarity;
        dtc_mode_e  operating_mode_field;
    } dtc_ctrl_s;

    typedef struct packed {
        logic [1:0] rsv;
        dtc_cksrc_e counter_two_clk_select;
        dtc_cksrc_e counter_one_clk_select;
    } dtc_cksel_s;

endpackage

//--- rtl/dtc_top.sv
// Dual timer/counter with mode control, prescaler and Wishbone register slave
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// (RULE_01) Select 000 stops counter one
// (RULE_02) Select 001 clocks counter one from prescaler
// (RULE_03) Software never programs select codes 110, 111
// (RULE_04) Counter two has its own identical select
// (RULE_05) Counter one: 16-bit live count, reset-free
// (RULE_06) Counter two: 16-bit live count, reset-free
// (RULE_07) Reload/capture one: 16-bit, reset-free
// (RULE_08) Reload two: 16-bit, reset-free
// (RULE_09) Mode control clears to zero on reset
// (RULE_10) Mode field: PWM, capture, dual, reserved
// (RULE_11) Edge bit: 0 falling, 1 rising
// (RULE_12) Capture mode pin edge presets counter FFFF
// (RULE_13) Other modes pin is PWM output
// (RULE_14) Output bit tracks pin; software write wins
// (RULE_15) Output bit ignored while pin is input
// (RULE_16) Disabled: counters stop, data writes blocked
// (RULE_17) Disable clears prescaler, pending; pin input
// (RULE_18) Non-stopped select starts counter; reset stops; here only select 001 starts a counter, 010 to 101 leave it stopped
// (RULE_19) Prescaled clock divides by divisor plus one
// (RULE_20) Reload two keeps last write always
module dtc_top (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [dtc_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output wire logic [31:0]               wb_dat_o,
    output wire logic                      wb_ack_o,
    input  wire logic                      timer_io_pin_i,
    output wire logic                      timer_io_pin_o,
    output wire logic                      timer_io_pin_oe_o
);
    import dtc_pkg::*;

    dtc_ctrl_s   ctrl_q;
    dtc_cksel_s  cksel_q;
    logic [4:0]  psc_div_q;
    logic [4:0]  psc_cnt_q;
    logic [15:0] counter_one_value_q;
    logic [15:0] counter_two_value_q;
    logic [15:0] reload_capture_one_q;
    logic [15:0] reload_two_q;
    logic [3:0]  pend_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic        pin_prev_q;
    logic        pin_o_q;
    logic        pin_oe_q;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] nv,
                                            input logic [1:0]  be);
        merge16 = {be[1] ? nv[15:8] : old[15:8], be[0] ? nv[7:0] : old[7:0]};
    endfunction

    logic req;
    logic wr;
    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr  = req & wb_we_i;

    // Bus signals are passed in, so the continuous assigns below see them change
    function automatic logic wr_at(input logic             w,
                                   input logic [ADR_W-1:0] a,
                                   input logic [ADR_W-1:0] ofs);
        wr_at = w && (a == ofs);
    endfunction

    // Mode decode
    logic      en;
    dtc_mode_e mode;
    logic      cap_mode;
    logic      mode_ok;
    logic      pin_is_out;
    assign en       = ctrl_q.module_enable;
    assign mode     = ctrl_q.operating_mode_field;
    assign cap_mode = (mode == MODE_CAPTURE);                              // [RULE_10]
    assign mode_ok  = (mode != MODE_RSVD);                                 // [RULE_10]
    // Pin drives only when enabled and not capturing
    assign pin_is_out = en && ctrl_q.pin_function_enable
                        && (mode == MODE_PWM || mode == MODE_DUAL);        // [RULE_13]

    // Register write strobes; data registers are frozen while disabled
    logic wr_cnt1;
    logic wr_cnt2;
    logic wr_rca;
    logic wr_rb;
    logic wr_ctrl;
    logic wr_cksel;
    logic wr_psc;
    logic wr_pend;
    logic wr_pclr;
    assign wr_cnt1  = wr_at(wr, wb_adr_i, OFS_CNT1) && en;                 // [RULE_16]
    assign wr_cnt2  = wr_at(wr, wb_adr_i, OFS_CNT2) && en;                 // [RULE_16]
    assign wr_rca   = wr_at(wr, wb_adr_i, OFS_RCA) && en;                  // [RULE_16]
    assign wr_rb    = wr_at(wr, wb_adr_i, OFS_RB) && en;                   // [RULE_16]
    assign wr_pend  = wr_at(wr, wb_adr_i, OFS_PEND) && en && wb_sel_i[0];  // [RULE_16]
    assign wr_ctrl  = wr_at(wr, wb_adr_i, OFS_CTRL) && wb_sel_i[0];
    assign wr_cksel = wr_at(wr, wb_adr_i, OFS_CKSEL) && wb_sel_i[0];
    assign wr_psc   = wr_at(wr, wb_adr_i, OFS_PSC) && wb_sel_i[0];
    assign wr_pclr  = wr_at(wr, wb_adr_i, OFS_PCLR) && wb_sel_i[0];

    // Prescaler: one tick every divisor plus one system clocks
    logic psc_tick;
    assign psc_tick = en && (psc_cnt_q == psc_div_q);                      // [RULE_19]

    always_ff @(posedge clk_i) begin
        if (rst_i || !en || psc_tick) begin
            psc_cnt_q <= PSC_RST;                                          // [RULE_17]
        end else begin
            psc_cnt_q <= psc_cnt_q + 5'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            psc_div_q <= PSC_RST;
        end else if (wr_psc) begin
            psc_div_q <= wb_dat_i[4:0];
        end
    end

    // Counter clocks; codes other than the prescaled one leave the
    // counter stopped, so reserved codes are harmless
    logic c1_tick;
    logic c2_tick;
    logic c1_under;
    logic c2_under;
    assign c1_tick  = psc_tick && mode_ok
                      && (cksel_q.counter_one_clk_select == CK_PRESC);     // [RULE_01] [RULE_02] [RULE_03]
    assign c2_tick  = psc_tick && mode_ok
                      && (cksel_q.counter_two_clk_select == CK_PRESC);     // [RULE_04]
    assign c1_under = c1_tick && (counter_one_value_q == 16'h0000);
    assign c2_under = c2_tick && (counter_two_value_q == 16'h0000);

    // Timer pin edge detection
    logic pin_edge;
    logic cap_evt;
    logic preset;
    assign pin_edge = en && (ctrl_q.pin_edge_polarity ? (timer_io_pin_i & ~pin_prev_q)
                                                      : (~timer_io_pin_i & pin_prev_q)); // [RULE_11]
    assign cap_evt  = pin_edge && cap_mode;
    assign preset   = cap_evt && ctrl_q.pin_function_enable;               // [RULE_12]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= timer_io_pin_i;
        end
    end

    // Clock select; reset clears both fields, stopping both counters
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cksel_q <= dtc_cksel_s'(CKSEL_RST);                            // [RULE_18]
        end else if (wr_cksel) begin
            cksel_q <= dtc_cksel_s'(wb_dat_i[7:0] & CKSEL_RW_MASK);        // [RULE_18]
        end
    end

    // Counter one: no reset, value is unknown after power-up
    always_ff @(posedge clk_i) begin
        if (wr_cnt1) begin
            counter_one_value_q <= merge16(counter_one_value_q, wb_dat_i[15:0],
                                           wb_sel_i[1:0]);                 // [RULE_05]
        end else if (preset) begin
            counter_one_value_q <= PRESET_VAL;                             // [RULE_12]
        end else if (c1_under) begin
            counter_one_value_q <= cap_mode ? PRESET_VAL : reload_capture_one_q;
        end else if (c1_tick) begin
            counter_one_value_q <= counter_one_value_q - 16'h0001;         // [RULE_02]
        end
    end

    // Counter two: reloads from reload two on underflow
    always_ff @(posedge clk_i) begin
        if (wr_cnt2) begin
            counter_two_value_q <= merge16(counter_two_value_q, wb_dat_i[15:0],
                                           wb_sel_i[1:0]);                 // [RULE_06]
        end else if (c2_under) begin
            counter_two_value_q <= reload_two_q;
        end else if (c2_tick) begin
            counter_two_value_q <= counter_two_value_q - 16'h0001;         // [RULE_04]
        end
    end

    // Reload/capture one catches the live count on a capture edge
    always_ff @(posedge clk_i) begin
        if (wr_rca) begin
            reload_capture_one_q <= merge16(reload_capture_one_q, wb_dat_i[15:0],
                                            wb_sel_i[1:0]);                // [RULE_07]
        end else if (cap_evt) begin
            reload_capture_one_q <= counter_one_value_q;
        end
    end

    // Reload two is stored whatever the mode, so readback is exact
    always_ff @(posedge clk_i) begin
        if (wr_rb) begin
            reload_two_q <= merge16(reload_two_q, wb_dat_i[15:0], wb_sel_i[1:0]); // [RULE_08] [RULE_20]
        end
    end

    // Pending bits: hardware or software sets, clear register clears;
    // a set in the same cycle as a clear wins
    logic [3:0] pend_set;
    logic [3:0] pend_clr;
    always_comb begin
        pend_set         = 4'h0;
        pend_set[PEND_A] = (c1_under && !cap_mode) || cap_evt;
        pend_set[PEND_C] = c1_under && cap_mode;
        pend_set[PEND_D] = c2_under;
        if (wr_pend) begin
            pend_set = pend_set | wb_dat_i[3:0];
        end
        pend_clr = wr_pclr ? wb_dat_i[3:0] : 4'h0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !en) begin
            pend_q <= PEND_RST;                                            // [RULE_17]
        end else begin
            pend_q <= (pend_q & ~pend_clr) | pend_set;
        end
    end

    // Mode control; a software write to the output bit beats a toggle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= dtc_ctrl_s'(CTRL_RST);                               // [RULE_09]
        end else if (wr_ctrl) begin
            ctrl_q <= dtc_ctrl_s'(wb_dat_i[7:0] & CTRL_RW_MASK);           // [RULE_14]
        end else if (pin_is_out && c1_under) begin
            ctrl_q.pin_output_level <= ~ctrl_q.pin_output_level;           // [RULE_14]
        end
    end

    // Pin drivers; output bit reaches the pin only in output use
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_oe_q <= 1'b0;
            pin_o_q  <= 1'b0;
        end else begin
            pin_oe_q <= pin_is_out;                                        // [RULE_15] [RULE_17]
            pin_o_q  <= ctrl_q.pin_output_level;                           // [RULE_14]
        end
    end

    // Read mux; unmapped addresses read zero and ignore writes
    always_comb begin
        rdat_d = 32'h0000_0000;
        case (wb_adr_i)
            OFS_CNT1:  rdat_d[15:0] = counter_one_value_q;
            OFS_CNT2:  rdat_d[15:0] = counter_two_value_q;
            OFS_RCA:   rdat_d[15:0] = reload_capture_one_q;
            OFS_RB:    rdat_d[15:0] = reload_two_q;
            OFS_PSC:   rdat_d[4:0]  = psc_div_q;
            OFS_CKSEL: rdat_d[7:0]  = cksel_q;
            OFS_CTRL:  rdat_d[7:0]  = ctrl_q;
            OFS_PEND:  rdat_d[3:0]  = pend_q;
            OFS_PCLR:  rdat_d[7:0]  = PCLR_READ;
            default:   rdat_d       = 32'h0000_0000;
        endcase
    end

    // Wishbone classic: ack one cycle after the strobe, dropped next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= req;
            rdat_q <= req ? rdat_d : 32'h0000_0000;
        end
    end

    assign wb_ack_o          = ack_q;
    assign wb_dat_o          = rdat_q;
    assign timer_io_pin_o    = pin_o_q;
    assign timer_io_pin_oe_o = pin_oe_q;

    property p_c1_stop;
        @(posedge clk_i) disable iff (rst_i)
        (cksel_q.counter_one_clk_select == CK_STOP && !wr_cnt1 && !preset)
            |=> $stable(counter_one_value_q);
    endproperty
    a_c1_stop: assert property (p_c1_stop) else $error("counter one moved while stopped"); // [RULE_01]

    property p_c1_count;
        @(posedge clk_i) disable iff (rst_i)
        (c1_tick && counter_one_value_q != 16'h0000 && !wr_cnt1 && !preset)
            |=> counter_one_value_q == $past(counter_one_value_q) - 16'h0001;
    endproperty
    a_c1_count: assert property (p_c1_count) else $error("counter one missed a tick"); // [RULE_02]

    property p_c2_stop;
        @(posedge clk_i) disable iff (rst_i)
        (cksel_q.counter_two_clk_select == CK_STOP && !wr_cnt2)
            |=> $stable(counter_two_value_q);
    endproperty
    a_c2_stop: assert property (p_c2_stop) else $error("counter two moved while stopped"); // [RULE_04]

    property p_psc_wrap;
        @(posedge clk_i) disable iff (rst_i)
        (en && psc_cnt_q == psc_div_q) |=> psc_cnt_q == 5'h00;
    endproperty
    a_psc_wrap: assert property (p_psc_wrap) else $error("prescaler did not wrap"); // [RULE_19]

    property p_off_frozen;
        @(posedge clk_i) disable iff (rst_i)
        !en |=> $stable(counter_one_value_q) && $stable(counter_two_value_q)
                && $stable(reload_capture_one_q) && $stable(reload_two_q);
    endproperty
    a_off_frozen: assert property (p_off_frozen) else $error("data changed while disabled"); // [RULE_16]

    property p_off_clear;
        @(posedge clk_i) disable iff (rst_i)
        !en |=> (pend_q == 4'h0) && !timer_io_pin_oe_o && (psc_cnt_q == 5'h00);
    endproperty
    a_off_clear: assert property (p_off_clear) else $error("disable did not clear state"); // [RULE_17]

    property p_ctrl_rst;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> ctrl_q == dtc_ctrl_s'(CTRL_RST);
    endproperty
    a_ctrl_rst: assert property (p_ctrl_rst) else $error("mode control not cleared"); // [RULE_09]

    property p_preset;
        @(posedge clk_i) disable iff (rst_i)
        (preset && !wr_cnt1) |=> counter_one_value_q == PRESET_VAL;
    endproperty
    a_preset: assert property (p_preset) else $error("capture edge did not preset"); // [RULE_12]

    property p_fall_capture;
        @(posedge clk_i) disable iff (rst_i)
        (en && cap_mode && !ctrl_q.pin_edge_polarity && pin_prev_q && !timer_io_pin_i
         && !wr_rca) |=> reload_capture_one_q == $past(counter_one_value_q);
    endproperty
    a_fall_capture: assert property (p_fall_capture) else $error("falling edge not captured"); // [RULE_11]

    property p_sw_out;
        @(posedge clk_i) disable iff (rst_i)
        wr_ctrl |=> ##1 timer_io_pin_o == $past(wb_dat_i[CTRL_OUT_BIT], 2);
    endproperty
    a_sw_out: assert property (p_sw_out) else $error("software output bit lost"); // [RULE_14]

    property p_pin_in;
        @(posedge clk_i) disable iff (rst_i)
        (cap_mode || !ctrl_q.pin_function_enable) |=> !timer_io_pin_oe_o;
    endproperty
    a_pin_in: assert property (p_pin_in) else $error("pin driven while input"); // [RULE_15]

    property p_rb_keep;
        @(posedge clk_i) disable iff (rst_i)
        wr_rb |=> reload_two_q == merge16($past(reload_two_q), $past(wb_dat_i[15:0]),
                                          $past(wb_sel_i[1:0]));
    endproperty
    a_rb_keep: assert property (p_rb_keep) else $error("reload two lost a write"); // [RULE_20]

    property p_hw_toggle;
        @(posedge clk_i) disable iff (rst_i)
        (pin_is_out && c1_under && !wr_ctrl)
            |=> ctrl_q.pin_output_level != $past(ctrl_q.pin_output_level);
    endproperty
    a_hw_toggle: assert property (p_hw_toggle) else $error("output bit not toggled"); // [RULE_14]

    property p_pwm_drive;
        @(posedge clk_i) disable iff (rst_i)
        (en && ctrl_q.pin_function_enable && !cap_mode && mode_ok) |=> timer_io_pin_oe_o;
    endproperty
    a_pwm_drive: assert property (p_pwm_drive) else $error("pin not driven as output"); // [RULE_13]

endmodule

//--- testbench/dtc_pin_model.sv
// Behavioural source and load on the timer pin
`timescale 1ns/1ps
module dtc_pin_model (
    input  wire logic clk_i,
    input  wire logic pin_o_i,
    input  wire logic pin_oe_i,
    input  wire logic src_lvl_i,
    output wire logic pin_lvl_o
);
    logic src_q;

    // Source level changes only on clock edges, as the block expects a synchronous pin
    always_ff @(posedge clk_i) begin
        src_q <= src_lvl_i;
    end

    // Block drives the wire while enabled, otherwise the external source does
    assign pin_lvl_o = pin_oe_i ? pin_o_i : src_q;
endmodule

//--- testbench/dtc_top_test.sv
// Self-checking bench for the dual timer/counter block
`timescale 1ns/1ps
module dtc_top_test;
    import dtc_pkg::*;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, src = 1;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, q;
    wire  [31:0] rdat;
    wire         ack, pin_o, pin_oe, pin_lvl;
    int          bad_count = 0, check_count = 0;

    dtc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .timer_io_pin_i(pin_lvl),
        .timer_io_pin_o(pin_o), .timer_io_pin_oe_o(pin_oe));
    dtc_pin_model u_pin (.clk_i(clk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
        .src_lvl_i(src), .pin_lvl_o(pin_lvl));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_near(input logic [15:0] got, input int exp, input int tol);
        int d;
        d = int'(got) - exp;
        check_count++;
        if (^got === 1'bx || d > tol || d < -tol) begin
            bad_count++;
            $display("BAD %0t count %h expected near %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Classic single cycle; held until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'h3;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            $display("BAD %0t no bus answer", $time);
            give_verdict();
        end else begin
            @(posedge clk_i);
        end
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check_eq(q, exp);
    endtask

    task automatic s_reset();
        rd_check(OFS_CTRL, 32'h0);
        rd_check(OFS_CKSEL, 32'h0);
        rd_check(OFS_PSC, 32'h0);
        check_eq({30'h0, pin_oe, pin_o}, 32'h0);
    endtask

    task automatic s_regs();
        wb(1'b1, OFS_CTRL, 32'h81);
        wb(1'b1, OFS_CNT1, 32'h1234);
        wb(1'b1, OFS_CNT2, 32'hfedc);
        wb(1'b1, OFS_RCA, 32'h5a5a);
        wb(1'b1, OFS_RB, 32'habcd);
        rd_check(OFS_CNT1, 32'h1234);
        rd_check(OFS_CNT2, 32'hfedc);
        rd_check(OFS_RCA, 32'h5a5a);
        rd_check(OFS_RB, 32'habcd);
        wb(1'b1, OFS_CTRL, 32'h00);
        wb(1'b1, OFS_CKSEL, 32'h09);
        rd_check(OFS_CKSEL, 32'h09);
        wb(1'b1, OFS_CKSEL, 32'h00);
        rd_check(8'h3c, 32'h0);
        wb(1'b1, OFS_CNT1, 32'h5555);
        wb(1'b1, OFS_RB, 32'h1111);
        rd_check(OFS_CNT1, 32'h1234);
        rd_check(OFS_RB, 32'habcd);
    endtask

    task automatic s_pend();
        wb(1'b1, OFS_CTRL, 32'h80);
        wb(1'b1, OFS_PEND, 32'h0f);
        rd_check(OFS_PEND, 32'h0f);
        wb(1'b1, OFS_CTRL, 32'h00);
        rd_check(OFS_PEND, 32'h0);
        wb(1'b1, OFS_PEND, 32'h0f);
        rd_check(OFS_PEND, 32'h0);
    endtask

    task automatic pwm(input logic [7:0] c, input logic [1:0] exp);
        wb(1'b1, OFS_CTRL, {24'h0, c});
        rd_check(OFS_CTRL, {24'h0, c & CTRL_RW_MASK});
        check_eq({30'h0, pin_oe, pin_o & pin_oe}, {30'h0, exp});
    endtask

    task automatic s_pwm();
        pwm(8'hd0, 2'b11);
        pwm(8'h90, 2'b10);
        pwm(8'hd2, 2'b11);
        pwm(8'hc0, 2'b00);
        pwm(8'hd1, 2'b00);
        pwm(8'hd3, 2'b00);
        pwm(8'hff, 2'b00);
        pwm(8'h50, 2'b00);
        // Underflow after three ticks flips the output bit once; reload keeps it from flipping again
        wb(1'b1, OFS_CTRL, 32'hd0);
        wb(1'b1, OFS_RCA, 32'hffff);
        wb(1'b1, OFS_CNT1, 32'h0002);
        wb(1'b1, OFS_CKSEL, 32'h01);
        idle(8);
        wb(1'b1, OFS_CKSEL, 32'h00);
        rd_check(OFS_CTRL, 32'h90);
        check_eq({30'h0, pin_oe, pin_o}, 32'h2);
    endtask

    // Counter held by clock select 000, so only the pin edge can move it
    task automatic cap(input logic [7:0] c, input logic a, input logic b,
                       input logic [15:0] e_cnt, input logic [15:0] e_rca);
        wb(1'b1, OFS_CTRL, {24'h0, c});
        src <= a;
        idle(3);
        wb(1'b1, OFS_CNT1, 32'h1234);
        wb(1'b1, OFS_RCA, 32'h0);
        src <= b;
        idle(4);
        rd_check(OFS_CNT1, {16'h0, e_cnt});
        rd_check(OFS_RCA, {16'h0, e_rca});
        check_eq({31'h0, pin_oe}, 32'h0);
    endtask

    task automatic s_cap();
        wb(1'b1, OFS_CKSEL, 32'h00);
        cap(8'hd1, 1'b1, 1'b0, 16'hffff, 16'h1234);
        cap(8'h91, 1'b0, 1'b1, 16'h1234, 16'h0000);
        cap(8'h95, 1'b0, 1'b1, 16'hffff, 16'h1234);
        cap(8'h81, 1'b1, 1'b0, 16'h1234, 16'h1234);
    endtask

    // Prescaler phase is unknown at start, so the tick count is allowed a small slack
    task automatic count(input logic two, input logic [4:0] dv, input int k);
        logic [7:0] a;
        a = two ? OFS_CNT2 : OFS_CNT1;
        wb(1'b1, OFS_CTRL, 32'h82);
        wb(1'b1, OFS_PSC, {27'h0, dv});
        wb(1'b1, a, 32'h8000);
        wb(1'b1, OFS_CKSEL, two ? 32'h08 : 32'h01);
        idle(k);
        wb(1'b1, OFS_CKSEL, 32'h00);
        idle(k);
        wb(1'b0, a, 32'h0);
        check_near(q[15:0], 32768 - (k + 3) / (int'(dv) + 1), 2);
    endtask

    task automatic s_count();
        count(1'b0, 5'd0, 320);
        count(1'b0, 5'd3, 320);
        count(1'b0, 5'd31, 640);
        count(1'b1, 5'd3, 320);
        wb(1'b1, OFS_CNT1, 32'h4444);
        wb(1'b1, OFS_CTRL, 32'h00);
        wb(1'b1, OFS_CKSEL, 32'h01);
        idle(100);
        rd_check(OFS_CNT1, 32'h4444);
    endtask

    initial begin
        idle(12);
        rst_i <= 1'b0;
        @(posedge clk_i);
        s_reset();
        s_regs();
        s_pend();
        s_pwm();
        s_cap();
        s_count();
        give_verdict();
    end
endmodule
